// *** verilog/lss_pkg.sv ***
// constants and types shared by the lamp strike and burst sequencer
package lss_pkg;
    // register byte offsets
    localparam logic [7:0] LSS_OFS_STATUS = 8'h00;
    localparam logic [7:0] LSS_OFS_BRIGHT = 8'h04;
    localparam logic [7:0] LSS_OFS_RUNDIV = 8'h08;
    localparam logic [7:0] LSS_OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] LSS_OFS_IRQ_MASK = 8'h10;
    // reset values and the run divider minimum
    localparam logic [11:0] LSS_RUNDIV_RST = 12'h301;
    localparam logic [7:0] LSS_BRIGHT_RST = 8'hFF;
    localparam logic [11:0] LSS_RUNDIV_MIN = 12'h00A;
    // irq bit positions
    localparam int LSS_IRQ_FAULT = 0;
    localparam int LSS_IRQ_RUN = 1;
    localparam int LSS_IRQ_MISS = 2;
    localparam int LSS_IRQ_W = 3;
    // sequencing counts and strike period scaling
    localparam int LSS_PWRON_PERIODS = 16384;
    localparam int LSS_CHECK_PERIODS = 8192;
    localparam logic [3:0] LSS_IGNITE_LAST = 4'h7;
    localparam logic [3:0] LSS_OPEN_MIN = 4'h8;
    localparam logic [3:0] LSS_ATTEMPT_LAST = 4'hE;
    localparam logic [9:0] LSS_STEP_LAST = 10'h3FF;
    localparam logic [3:0] LSS_PULSE_LAST = 4'hF;
    localparam logic [17:0] LSS_STRIKE_LIMIT = 18'h3C000;
    localparam int LSS_STEP_SHIFT = 10;
    localparam logic [11:0] LSS_TOP_RATIO = 12'h005;
    // three-level input codes
    localparam logic [1:0] LSS_TRI_LOW = 2'h0;
    localparam logic [1:0] LSS_TRI_FLOAT = 2'h1;
    localparam logic [1:0] LSS_TRI_HIGH = 2'h2;
    // burst dividers and duty thresholds
    localparam logic [3:0] LSS_DIV_HIGH = 4'h2;
    localparam logic [3:0] LSS_DIV_FLOAT = 4'h4;
    localparam logic [3:0] LSS_DIV_LOW = 4'h8;
    localparam logic [6:0] LSS_BURST_FULL = 7'h40;
    localparam logic [6:0] LSS_BURST_MIN = 7'h06;
    localparam logic [6:0] LSS_BURST_SPAN = 7'h3A;

    typedef enum logic [2:0] {
        LSS_ST_IDLE = 3'b000,
        LSS_ST_PWRON = 3'b001,
        LSS_ST_STRIKE = 3'b010,
        LSS_ST_RUN = 3'b011,
        LSS_ST_FAULT = 3'b100
    } lss_state_e;
endpackage

// *** verilog/lss_burst.sv ***
// burst dimming clock divider and duty comparator
`timescale 1ns/1ns
module lss_burst
    import lss_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic per_tick_i,
    input wire logic [1:0] dimming_select_i,
    input wire logic [1:0] div_select_i,
    input wire logic burst_clock_polarity_input_i,
    input wire logic [7:0] brightness_i,
    output logic burst_on_o
);
    import lss_pkg::*;

    typedef struct packed {
        logic ext_q;
        logic [3:0] pre;
        logic [5:0] ramp;
        logic on;
    } lss_burst_s;

    lss_burst_s s_r;
    lss_burst_s s_nxt;
    logic internal;
    logic src_tick;
    logic [3:0] div;
    logic [7:0] b;
    logic [6:0] thr;
    logic [15:0] prod;

    always_comb begin
        s_nxt = s_r;
        internal = (dimming_select_i == LSS_TRI_LOW);
        s_nxt.ext_q = burst_clock_polarity_input_i;
        // internal source is the drive period end tick itself, one per period
        src_tick = internal ? per_tick_i
                 : (burst_clock_polarity_input_i && !s_r.ext_q);
        case (div_select_i)
            LSS_TRI_HIGH: div = LSS_DIV_HIGH;
            LSS_TRI_FLOAT: div = LSS_DIV_FLOAT;
            default: div = LSS_DIV_LOW;
        endcase
        if (internal) begin
            // 16 wraps to zero; the 4-bit pre then runs all 16 states
            div = {div[2:0], 1'b0};
        end
        // reverse polarity only outside external clock mode
        b = (internal && !burst_clock_polarity_input_i) ? ~brightness_i
            : brightness_i;
        prod = 16'(b) * 16'(LSS_BURST_SPAN);
        thr = (b == 8'hFF) ? LSS_BURST_FULL
            : LSS_BURST_MIN + 7'(prod[15:8]);
        if (!run_i) begin
            s_nxt.pre = 4'h0;
            s_nxt.ramp = 6'h00;
        end else if (src_tick) begin
            if (s_r.pre == div - 4'h1) begin
                s_nxt.pre = 4'h0;
                s_nxt.ramp = s_r.ramp + 6'h01;
            end else begin
                s_nxt.pre = s_r.pre + 4'h1;
            end
        end
        if (dimming_select_i == LSS_TRI_FLOAT
            || dimming_select_i == 2'h3) begin
            s_nxt.on = 1'b1;
        end else begin
            s_nxt.on = {1'b0, s_r.ramp} < thr;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
            // pin idles high; avoids a false clock edge after reset
            s_r.ext_q <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign burst_on_o = s_r.on;

    a_analog_full: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        dimming_select_i == LSS_TRI_FLOAT |=> burst_on_o)
        else $error("analog mode must keep burst on");
endmodule

// *** verilog/lss_seq.sv ***
// lamp strike, run check, fault and burst sequencer with avalon registers
`timescale 1ns/1ns
module lss_seq
    import lss_pkg::*;
#(
    parameter int PWRON_PERIODS = LSS_PWRON_PERIODS,
    parameter int CHECK_PERIODS = LSS_CHECK_PERIODS
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic lamp_current_sense_i,
    input wire logic overvoltage_sense_i,
    input wire logic [1:0] dimming_select_i,
    input wire logic [1:0] div_select_i,
    input wire logic burst_clock_polarity_input_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic drive_a_o,
    output logic drive_b_o,
    output logic fault_filter_node_o,
    output logic irq_o
);
    import lss_pkg::*;

    localparam logic [13:0] PWRON_LAST = 14'(PWRON_PERIODS - 1);
    localparam logic [12:0] CHECK_LAST = 13'(CHECK_PERIODS - 1);

    typedef struct packed {
        lss_state_e st;
        logic [11:0] pcnt;
        logic seen;
        logic ov;
        logic [13:0] dcnt;
        logic [3:0] pulse;
        logic [9:0] step;
        logic [3:0] att;
        logic [3:0] ign;
        logic [12:0] chk;
        logic [3:0] runcyc;
        logic [17:0] stot;
        logic drv_a;
        logic drv_b;
        logic fnode;
        logic [7:0] bright;
        logic [11:0] rundiv;
        logic [LSS_IRQ_W-1:0] mask;
        logic [LSS_IRQ_W-1:0] ist;
        logic wait_q;
        logic [31:0] rdata;
        logic irq;
    } lss_seq_s;

    lss_seq_s s_r;
    lss_seq_s s_nxt;
    logic burst_on;
    logic per_end;
    logic [11:0] cur_per;
    logic [LSS_IRQ_W-1:0] ev;
    logic cyc_hit;
    logic sweep_end;
    logic acc;
    logic drive_en;

    // period shrinks linearly from run period to a fifth of it
    function automatic logic [11:0] strike_period(input logic [11:0] rdiv,
                                                  input logic [9:0] stp);
        logic [11:0] span;
        logic [21:0] prod;
        span = rdiv - rdiv / LSS_TOP_RATIO;
        prod = 22'(span) * 22'(stp) + 22'(span);
        strike_period = rdiv - 12'(prod >> LSS_STEP_SHIFT);
    endfunction

    lss_burst lss_burst_inst (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .run_i(s_r.st == LSS_ST_RUN),
        .per_tick_i(per_end),
        .dimming_select_i(dimming_select_i),
        .div_select_i(div_select_i),
        .burst_clock_polarity_input_i(burst_clock_polarity_input_i),
        .brightness_i(s_r.bright),
        .burst_on_o(burst_on)
    );

    always_comb begin
        s_nxt = s_r;
        ev = '0;
        acc = (avs_read_i || avs_write_i) && !s_r.wait_q;
        cur_per = (s_r.st == LSS_ST_STRIKE)
            ? strike_period(s_r.rundiv, s_r.step) : s_r.rundiv;
        per_end = (s_r.st != LSS_ST_IDLE) && (s_r.pcnt >= cur_per - 12'h001);
        // one lamp cycle is any drive period in which current was seen
        cyc_hit = s_r.seen || lamp_current_sense_i;
        sweep_end = (s_r.pulse == LSS_PULSE_LAST)
            && (s_r.step == LSS_STEP_LAST);
        s_nxt.pcnt = per_end ? 12'h000 : s_r.pcnt + 12'h001;
        if (per_end) begin
            s_nxt.seen = 1'b0;
            s_nxt.ov = 1'b0;
        end else begin
            s_nxt.seen = cyc_hit;
            s_nxt.ov = s_r.ov || overvoltage_sense_i;
        end
        case (s_r.st)
            LSS_ST_IDLE: begin
                s_nxt.pcnt = 12'h000;
                s_nxt.dcnt = '0;
                s_nxt.st = LSS_ST_PWRON;
            end
            LSS_ST_PWRON: begin
                if (per_end) begin
                    s_nxt.dcnt = s_r.dcnt + 14'h0001;
                    if (s_r.dcnt == PWRON_LAST) begin
                        s_nxt.st = LSS_ST_STRIKE;
                        s_nxt.pulse = '0;
                        s_nxt.step = '0;
                        s_nxt.att = '0;
                        s_nxt.ign = '0;
                        s_nxt.stot = '0;
                    end
                end
            end
            LSS_ST_STRIKE: begin
                if (per_end) begin
                    s_nxt.stot = s_r.stot + 18'h00001;
                    s_nxt.pulse = s_r.pulse + 4'h1;
                    if (cyc_hit) begin
                        s_nxt.ign = s_r.ign + 4'h1;
                    end
                    // overvoltage holds the step where it is
                    if (s_r.pulse == LSS_PULSE_LAST && !s_r.ov
                        && !overvoltage_sense_i) begin
                        s_nxt.step = s_r.step + 10'h001;
                    end
                    if (cyc_hit && s_r.ign == LSS_IGNITE_LAST) begin
                        s_nxt.st = LSS_ST_RUN;
                        s_nxt.chk = '0;
                        s_nxt.runcyc = '0;
                        ev[LSS_IRQ_RUN] = 1'b1;
                    end else if ((sweep_end && !s_r.ov
                                  && !overvoltage_sense_i
                                  && s_r.att == LSS_ATTEMPT_LAST)
                                 || s_r.stot == LSS_STRIKE_LIMIT
                                     - 18'h00001) begin
                        s_nxt.st = LSS_ST_FAULT;
                        ev[LSS_IRQ_FAULT] = 1'b1;
                    end else if (sweep_end && !s_r.ov
                                 && !overvoltage_sense_i) begin
                        s_nxt.att = s_r.att + 4'h1;
                        s_nxt.ign = '0;
                        ev[LSS_IRQ_MISS] = 1'b1;
                    end
                end
            end
            LSS_ST_RUN: begin
                if (per_end) begin
                    s_nxt.chk = s_r.chk + 13'h0001;
                    if (cyc_hit && s_r.runcyc != LSS_OPEN_MIN) begin
                        s_nxt.runcyc = s_r.runcyc + 4'h1;
                    end
                    if (s_r.chk == CHECK_LAST) begin
                        s_nxt.chk = '0;
                        s_nxt.runcyc = '0;
                        if (s_r.runcyc < LSS_OPEN_MIN
                            && !(cyc_hit
                                 && s_r.runcyc == LSS_OPEN_MIN - 4'h1)) begin
                            s_nxt.st = LSS_ST_FAULT;
                            ev[LSS_IRQ_FAULT] = 1'b1;
                        end
                    end
                end
            end
            LSS_ST_FAULT: begin
                s_nxt.pcnt = 12'h000;
            end
            default: begin
                s_nxt.st = LSS_ST_IDLE;
            end
        endcase
        if (!enable_i) begin
            s_nxt.st = LSS_ST_IDLE;
        end
        // drives follow the counter; a half period each
        drive_en = (s_r.st == LSS_ST_STRIKE)
            || (s_r.st == LSS_ST_RUN && burst_on);
        s_nxt.drv_a = enable_i && drive_en && !per_end
            && (s_nxt.pcnt < (cur_per >> 1));
        s_nxt.drv_b = enable_i && drive_en && !per_end
            && (s_nxt.pcnt >= (cur_per >> 1));
        s_nxt.fnode = (s_nxt.st == LSS_ST_FAULT);
        // bus slave: one wait state; waitrequest drops in the cycle after
        // a request is first seen and rises again as it is taken
        s_nxt.wait_q = !((avs_read_i || avs_write_i) && s_r.wait_q);
        if ((avs_read_i || avs_write_i) && s_r.wait_q) begin
            s_nxt.rdata = '0;
            case (avs_address_i)
                LSS_OFS_STATUS: s_nxt.rdata = {23'h0, burst_on,
                    s_r.att, s_r.fnode, s_r.st};
                LSS_OFS_BRIGHT: s_nxt.rdata = {24'h0, s_r.bright};
                LSS_OFS_RUNDIV: s_nxt.rdata = {20'h0, s_r.rundiv};
                LSS_OFS_IRQ_STAT: s_nxt.rdata = 32'(s_r.ist);
                LSS_OFS_IRQ_MASK: s_nxt.rdata = 32'(s_r.mask);
                default: s_nxt.rdata = '0;
            endcase
        end
        if (acc && avs_read_i && avs_address_i == LSS_OFS_IRQ_STAT) begin
            s_nxt.ist = ev;
        end else begin
            s_nxt.ist = s_r.ist | ev;
        end
        if (acc && avs_write_i) begin
            case (avs_address_i)
                LSS_OFS_BRIGHT: begin
                    if (avs_byteenable_i[0]) begin
                        s_nxt.bright = avs_writedata_i[7:0];
                    end
                end
                LSS_OFS_RUNDIV: begin
                    if (avs_byteenable_i[1:0] == 2'h3) begin
                        // too short a period would break the sweep
                        s_nxt.rundiv = (avs_writedata_i[11:0]
                            < LSS_RUNDIV_MIN) ? LSS_RUNDIV_MIN
                            : avs_writedata_i[11:0];
                    end
                end
                LSS_OFS_IRQ_MASK: begin
                    if (avs_byteenable_i[0]) begin
                        s_nxt.mask = avs_writedata_i[LSS_IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        s_nxt.irq = |(s_nxt.ist & s_nxt.mask);
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.st <= LSS_ST_IDLE;
            s_r.bright <= LSS_BRIGHT_RST;
            s_r.rundiv <= LSS_RUNDIV_RST;
            s_r.wait_q <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata_o = s_r.rdata;
    assign avs_waitrequest_o = s_r.wait_q;
    assign drive_a_o = s_r.drv_a;
    assign drive_b_o = s_r.drv_b;
    assign fault_filter_node_o = s_r.fnode;
    assign irq_o = s_r.irq;

    a_fault_node_high: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        s_r.st == LSS_ST_FAULT && enable_i |=> fault_filter_node_o)
        else $error("fault node not high in fault");
    a_disable_to_idle: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !enable_i |=> s_r.st == LSS_ST_IDLE && !drive_a_o && !drive_b_o)
        else $error("disable did not idle the sequencer");
    a_pwron_no_drive: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        s_r.st == LSS_ST_PWRON |=> !drive_a_o && !drive_b_o)
        else $error("drive active during power-on delay");
    a_pwron_exit: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        s_r.st == LSS_ST_PWRON && per_end && s_r.dcnt == PWRON_LAST
        && enable_i |=> s_r.st == LSS_ST_STRIKE)
        else $error("power-on delay length wrong");
    a_ignite_run: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        s_r.st == LSS_ST_STRIKE && per_end && cyc_hit
        && s_r.ign == LSS_IGNITE_LAST && enable_i
        |=> s_r.st == LSS_ST_RUN)
        else $error("no run entry after eight cycles");
    a_step_advance: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        s_r.st == LSS_ST_STRIKE && per_end && !sweep_end
        && s_r.pulse == LSS_PULSE_LAST && !s_r.ov && !overvoltage_sense_i
        |=> s_r.step == $past(s_r.step) + 10'h001)
        else $error("strike step did not advance after 16 pulses");
    a_strike_pulses: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        s_r.st == LSS_ST_STRIKE && s_r.pulse != LSS_PULSE_LAST
        |=> s_r.step == $past(s_r.step))
        else $error("strike step moved before 16 pulses");
    a_check_count: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        s_r.st == LSS_ST_RUN && per_end && s_r.chk != CHECK_LAST
        |=> s_r.chk == $past(s_r.chk) + 13'h0001)
        else $error("check interval counter did not advance");
    a_cycle_seen: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        lamp_current_sense_i && !per_end |=> s_r.seen)
        else $error("lamp current not recorded for the period");
    a_open_lamp: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        s_r.st == LSS_ST_RUN && per_end && s_r.chk == CHECK_LAST
        && s_r.runcyc < LSS_OPEN_MIN - 4'h1 && enable_i
        |=> s_r.st == LSS_ST_FAULT)
        else $error("open lamp not declared");
    a_sweep_fault: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        s_r.st == LSS_ST_STRIKE && per_end && sweep_end
        && s_r.att == LSS_ATTEMPT_LAST && !cyc_hit && !s_r.ov
        && !overvoltage_sense_i && enable_i |=> s_r.st == LSS_ST_FAULT)
        else $error("fifteenth failed sweep did not fault");
    a_fault_latched: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        s_r.st == LSS_ST_FAULT && enable_i
        |=> s_r.st == LSS_ST_FAULT ##1 !drive_a_o && !drive_b_o)
        else $error("fault did not stay latched");
    a_top_strike: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        s_r.st == LSS_ST_STRIKE && s_r.step == LSS_STEP_LAST
        |-> cur_per == s_r.rundiv / LSS_TOP_RATIO
            || cur_per == s_r.rundiv / LSS_TOP_RATIO + 12'h001)
        else $error("top strike period not a fifth of run period");
endmodule

// *** verification/lss_lamp_model.sv ***
// fet pair, transformer and lamp as seen by the sense comparators
`timescale 1ns/1ns
module lss_lamp_model (
    input wire logic drive_a_i,
    input wire logic drive_b_i,
    input wire logic lit_i,
    input wire logic overvolt_i,
    output logic lamp_current_sense_o,
    output logic overvoltage_sense_o
);
    // no current unless a lit lamp is driven; comparators idle low
    assign lamp_current_sense_o = lit_i & (drive_a_i | drive_b_i);
    // an unlit lamp only shows high voltage while driven
    assign overvoltage_sense_o = overvolt_i & ~lit_i & (drive_a_i | drive_b_i);
endmodule

// *** verification/test_lss_seq.sv ***
// register level test of the lamp strike and burst sequencer
`timescale 1ns/1ns
module test_lss_seq;
    import lss_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic enable_i = 1'b0;
    logic lit = 1'b0;
    logic ovr = 1'b0;
    logic [1:0] dimming_select_i = LSS_TRI_FLOAT;
    logic [1:0] div_select_i = LSS_TRI_FLOAT;
    logic pol = 1'b1;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic drive_a_o;
    logic drive_b_o;
    logic fault_filter_node_o;
    logic irq_o;
    logic lamp;
    logic ovs;
    logic [31:0] q;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int hits;

    always #10 clk_sys_i = ~clk_sys_i;

    // short power-on and check counts keep the run brief
    lss_seq #(.PWRON_PERIODS(4), .CHECK_PERIODS(16)) lss_seq_inst (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .enable_i(enable_i),
        .lamp_current_sense_i(lamp),
        .overvoltage_sense_i(ovs),
        .dimming_select_i(dimming_select_i),
        .div_select_i(div_select_i),
        .burst_clock_polarity_input_i(pol),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .drive_a_o(drive_a_o),
        .drive_b_o(drive_b_o),
        .fault_filter_node_o(fault_filter_node_o),
        .irq_o(irq_o)
    );

    lss_lamp_model lss_lamp_model_inst (
        .drive_a_i(drive_a_o),
        .drive_b_i(drive_b_o),
        .lit_i(lit),
        .overvolt_i(ovr),
        .lamp_current_sense_o(lamp),
        .overvoltage_sense_o(ovs)
    );

    task automatic end_of_test();
        $display("checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= ~w;
        avs_write_i <= w;
        // only the bench timeout ends a wait that never gets its answer
        do begin
            @(posedge clk_sys_i);
        end while (avs_waitrequest_o !== 1'b0);
        r = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h00000000, r);
        check(r, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    // polls the state field; the poll spacing is far below a run period
    task automatic wait_state(input logic [2:0] s);
        logic [31:0] r;
        int k;
        k = 0;
        do begin
            bus(1'b0, LSS_OFS_STATUS, 32'h00000000, r);
            k++;
        end while (r[2:0] !== s && k < 400);
        check({29'h0, r[2:0]}, {29'h0, s});
    endtask

    task automatic count_drive(input int n);
        hits = 0;
        repeat (n) begin
            @(posedge clk_sys_i);
            if (drive_a_o !== 1'b0 || drive_b_o !== 1'b0) hits++;
        end
    endtask

    // whole sequence needs under two thousand cycles
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("Error at %0t: run too long", $time);
            end_of_test();
        end
    end

    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        // analog mode keeps the burst bit set even while idle
        rd(LSS_OFS_STATUS, 32'h00000100);
        rd(LSS_OFS_BRIGHT, {24'h0, LSS_BRIGHT_RST});
        rd(LSS_OFS_RUNDIV, {20'h0, LSS_RUNDIV_RST});
        rd(LSS_OFS_IRQ_MASK, 32'h00000000);
        rd(LSS_OFS_IRQ_STAT, 32'h00000000);
        rd(8'h20, 32'h00000000);
        wr(8'h20, 32'h000000FF);
        rd(8'h20, 32'h00000000);
        wr(LSS_OFS_STATUS, 32'h000000FF);
        rd(LSS_OFS_STATUS, 32'h00000100);
        wr(LSS_OFS_BRIGHT, 32'h0000005A);
        rd(LSS_OFS_BRIGHT, 32'h0000005A);
        wr(LSS_OFS_RUNDIV, {20'h0, LSS_RUNDIV_MIN});
        rd(LSS_OFS_RUNDIV, {20'h0, LSS_RUNDIV_MIN});
        lit <= 1'b1;
        count_drive(20);
        check(hits, 0);
        enable_i <= 1'b1;
        rd(LSS_OFS_STATUS, 32'h00000101);
        // 4 periods of 10 clocks, minus the read above
        count_drive(30);
        check(hits, 0);
        wait_state(3'h2);
        wait_state(3'h3);
        check({31'h0, irq_o}, 32'h0);
        wr(LSS_OFS_IRQ_MASK, 32'h00000007);
        repeat (2) @(posedge clk_sys_i);
        check({31'h0, irq_o}, 32'h1);
        rd(LSS_OFS_IRQ_STAT, 32'h00000002);
        repeat (2) @(posedge clk_sys_i);
        check({31'h0, irq_o}, 32'h0);
        rd(LSS_OFS_STATUS, 32'h00000103);
        // three check intervals with a healthy lamp
        count_drive(480);
        check({31'h0, hits > 0}, 32'h1);
        rd(LSS_OFS_STATUS, 32'h00000103);
        // internal burst at full demand keeps nearly every cycle driven
        wr(LSS_OFS_BRIGHT, 32'h000000FF);
        dimming_select_i <= LSS_TRI_LOW;
        count_drive(480);
        check({31'h0, hits >= 400}, 32'h1);
        rd(LSS_OFS_STATUS, 32'h00000103);
        lit <= 1'b0;
        wait_state(3'h4);
        @(posedge clk_sys_i);
        check({31'h0, fault_filter_node_o}, 32'h1);
        count_drive(100);
        check(hits, 0);
        check({31'h0, irq_o}, 32'h1);
        rd(LSS_OFS_IRQ_STAT, 32'h00000001);
        bus(1'b0, LSS_OFS_STATUS, 32'h00000000, q);
        check(q & 32'h0000000F, 32'h0000000C);
        check({31'h0, fault_filter_node_o}, 32'h1);
        enable_i <= 1'b0;
        wait_state(3'h0);
        @(posedge clk_sys_i);
        check({31'h0, fault_filter_node_o}, 32'h0);
        end_of_test();
    end
endmodule
